/* verilog/rrp_framer.sv */
// Operation
// - Send a remote access packet that reads one register of a remote node's PHY.
// - Top two bits of the first quadlet of request and reply are 00.
// - Destination node number sits in bits 29 to 24 of the first quadlet.
// - Extended kind 1 asks for a read of the base register set.
// - Extended kind 5 asks for a read of the paged register set.
// - Bank and socket fields act as the remote page and port selects.
// - A base read addresses one of the first eight PHY registers directly.
// - A paged read addresses register 1000b plus the target entry index.
// - Second quadlet is the bitwise complement of the first; receiver may check it.
// - Accept the remote reply that answers an earlier request.
// - The control token records the received packet length in quadlets.
// - Token self-identification flag is 1 only for a self-identification packet.
// - Token physical-layer-packet flag is 1 for every PHY packet that is not a self-identification packet.
// - Token carries the five-bit acknowledge value returned for the packet.
// - Token reports how many fill bytes were added; the code always reports zero.
// - Token rate code gives arrival speed; 00/01/10 = 100/200/400, 11 unsupported.
// - Reply fields decode with the same layout and meaning as the request.
`timescale 1ns/1ns
module rrp_framer (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    // Host request
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire logic                        req_paged,
    input  wire logic [5:0]                  req_dest_node,
    input  wire logic [2:0]                  req_bank,
    input  wire logic [3:0]                  req_socket,
    input  wire logic [2:0]                  req_index,
    output logic [3:0]                       req_target_register,
    // Transmit quadlets toward the local PHY
    output logic                             tx_valid,
    input  wire logic                        tx_ready,
    output logic [rrp_pkg::QUAD_W-1:0]       tx_data,
    output logic                             tx_last,
    // Receive quadlets from the local PHY
    input  wire logic                        rx_valid,
    input  wire logic [rrp_pkg::QUAD_W-1:0]  rx_data,
    input  wire logic                        rx_last,
    input  wire logic                        rx_selfid,
    input  wire logic [4:0]                  rx_ack,
    input  wire logic [1:0]                  rx_speed,
    // Reply toward the host
    output logic                             rpl_valid,
    output logic                             rpl_check_ok,
    output logic                             rpl_expected,
    output logic [5:0]                       rpl_dest_node,
    output logic                             rpl_paged,
    output logic [2:0]                       rpl_bank,
    output logic [3:0]                       rpl_socket,
    output logic [2:0]                       rpl_index,
    output logic [3:0]                       rpl_target_register,
    // Packet control token of the last received packet
    output logic                             token_valid,
    output logic [rrp_pkg::QUAD_W-1:0]       token_quadlet,
    output logic [rrp_pkg::TOK_LEN_W-1:0]    token_length_quadlets,
    output logic                             token_selfid,
    output logic                             token_phy_packet,
    output logic [4:0]                       acknowledge_value,
    output logic [1:0]                       token_pad,
    output logic [1:0]                       token_rate,
    output logic                             token_rate_unsupported,
    // Request in flight
    output logic                             req_outstanding
);
    import rrp_pkg::*;

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    function automatic logic [QUAD_W-1:0] build_first(
        input logic       paged,
        input logic [5:0] dest,
        input logic [2:0] bank,
        input logic [3:0] sock,
        input logic [2:0] idx
    );
        logic [QUAD_W-1:0] q;
        q                  = '0;
        q[PID_HI:PID_LO]   = PID_PHY;
        q[DEST_HI:DEST_LO] = dest;
        q[ZERO_HI:ZERO_LO] = 2'h0;
        q[KIND_HI:KIND_LO] = paged ? KIND_PAGED : KIND_BASE;
        q[BANK_HI:BANK_LO] = bank;
        q[SOCK_HI:SOCK_LO] = sock;
        q[IDX_HI:IDX_LO]   = idx;
        q[EXT_HI:EXT_LO]   = EXT_PATTERN;
        q[RSV_HI:RSV_LO]   = 4'h0;
        return q;
    endfunction

    // The remote register the read lands on, used for request and reply.
    function automatic logic [3:0] target_reg(
        input logic       paged,
        input logic [2:0] idx
    );
        logic [3:0] r;
        if (paged) begin
            r = PAGED_BASE + {1'b0, idx};
        end else begin
            r = {1'b0, idx};
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Request framing
    // ------------------------------------------------------------------
    rrp_tx_state_t     tx_state;
    logic [QUAD_W-1:0] tx_first;
    logic              req_take;
    logic              tx_done;

    assign req_take = req_valid && req_ready;
    assign tx_done  = (tx_state == RRP_TX_SECOND) && tx_ready;

    // The first quadlet is held so the complement can be sent without
    // the host keeping its fields steady after the handshake.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_state  <= RRP_TX_IDLE;
            tx_first  <= '0;
            tx_valid  <= 1'b0;
            tx_data   <= '0;
            tx_last   <= 1'b0;
            req_ready <= 1'b0;
        end else begin
            unique case (tx_state)
                RRP_TX_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_take) begin
                        tx_first  <= build_first(req_paged, req_dest_node, req_bank, req_socket, req_index);
                        tx_data   <= build_first(req_paged, req_dest_node, req_bank, req_socket, req_index);
                        tx_valid  <= 1'b1;
                        tx_last   <= 1'b0;
                        req_ready <= 1'b0;
                        tx_state  <= RRP_TX_FIRST;
                    end
                end
                RRP_TX_FIRST: begin
                    if (tx_ready) begin
                        tx_data  <= ~tx_first;
                        tx_last  <= 1'b1;
                        tx_state <= RRP_TX_SECOND;
                    end
                end
                RRP_TX_SECOND: begin
                    if (tx_ready) begin
                        tx_valid  <= 1'b0;
                        tx_last   <= 1'b0;
                        req_ready <= 1'b1;
                        tx_state  <= RRP_TX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            req_target_register <= 4'h0;
        end else if (req_take) begin
            req_target_register <= target_reg(req_paged, req_index);
        end
    end

    // ------------------------------------------------------------------
    // Reply reception
    // ------------------------------------------------------------------
    logic [TOK_LEN_W-1:0] rx_count;
    logic [TOK_LEN_W-1:0] next_length;
    logic [QUAD_W-1:0]    rx_first;
    logic [QUAD_W-1:0]    rx_second;
    logic [QUAD_W-1:0]    next_second;
    logic                 rx_end;
    logic                 next_phy;
    logic                 next_is_reply;
    logic [3:0]           rx_kind;

    assign rx_end      = rx_valid && rx_last;
    assign next_length = rx_count + {{(TOK_LEN_W-1){1'b0}}, 1'b1};
    assign next_second = (rx_count < REPLY_LEN) ? rx_data : rx_second;
    assign rx_kind     = (rx_count == '0) ? rx_data[KIND_HI:KIND_LO] : rx_first[KIND_HI:KIND_LO];
    assign next_phy    = !rx_selfid &&
                         (((rx_count == '0) ? rx_data[PID_HI:PID_LO] : rx_first[PID_HI:PID_LO]) == PID_PHY);
    assign next_is_reply = next_phy && (next_length == REPLY_LEN) &&
                           ((rx_kind == KIND_BASE) || (rx_kind == KIND_PAGED));

    // Quadlets are counted as they pass; a packet of any length closes on
    // its last strobe so a foreign packet cannot wedge the parser.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rx_count  <= '0;
            rx_first  <= '0;
            rx_second <= '0;
        end else if (rx_valid) begin
            if (rx_count == '0) begin
                rx_first <= rx_data;
            end
            rx_second <= next_second;
            rx_count  <= rx_last ? '0 : next_length;
        end
    end

    // Decoded reply fields, presented together with a one-cycle strobe.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rpl_valid           <= 1'b0;
            rpl_check_ok        <= 1'b0;
            rpl_expected        <= 1'b0;
            rpl_dest_node       <= 6'h0;
            rpl_paged           <= 1'b0;
            rpl_bank            <= 3'h0;
            rpl_socket          <= 4'h0;
            rpl_index           <= 3'h0;
            rpl_target_register <= 4'h0;
        end else begin
            rpl_valid <= rx_end && next_is_reply;
            if (rx_end && next_is_reply) begin
                rpl_check_ok        <= (next_second == ~rx_first);
                rpl_expected        <= req_outstanding;
                rpl_dest_node       <= rx_first[DEST_HI:DEST_LO];
                rpl_paged           <= (rx_kind == KIND_PAGED);
                rpl_bank            <= rx_first[BANK_HI:BANK_LO];
                rpl_socket          <= rx_first[SOCK_HI:SOCK_LO];
                rpl_index           <= rx_first[IDX_HI:IDX_LO];
                rpl_target_register <= target_reg(rx_kind == KIND_PAGED, rx_first[IDX_HI:IDX_LO]);
            end
        end
    end

    // A completed request waits for its reply; a finishing request beats
    // a reply arriving in the same cycle.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            req_outstanding <= 1'b0;
        end else if (tx_done) begin
            req_outstanding <= 1'b1;
        end else if (rx_end && next_is_reply) begin
            req_outstanding <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Packet control token
    // ------------------------------------------------------------------
    // Quadlet-aligned PHY traffic never needs fill bytes, so the pad count
    // is always reported as zero.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            token_valid            <= 1'b0;
            token_quadlet          <= '0;
            token_length_quadlets  <= '0;
            token_selfid           <= 1'b0;
            token_phy_packet       <= 1'b0;
            acknowledge_value      <= 5'h0;
            token_pad              <= PAD_NONE;
            token_rate             <= RATE_100;
            token_rate_unsupported <= 1'b0;
        end else begin
            token_valid <= rx_end;
            if (rx_end) begin
                token_length_quadlets              <= next_length;
                token_selfid                       <= rx_selfid;
                token_phy_packet                   <= next_phy;
                acknowledge_value                  <= rx_ack;
                token_pad                          <= PAD_NONE;
                token_rate                         <= rx_speed;
                token_rate_unsupported             <= (rx_speed == RATE_BAD);
                token_quadlet                      <= '0;
                token_quadlet[TOK_LEN_HI:TOK_LEN_LO] <= next_length;
                token_quadlet[TOK_SELF]            <= rx_selfid;
                token_quadlet[TOK_PHY]             <= next_phy;
                token_quadlet[TOK_ACK_HI:TOK_ACK_LO] <= rx_ack;
                token_quadlet[TOK_PAD_HI:TOK_PAD_LO] <= PAD_NONE;
                token_quadlet[TOK_SPD_HI:TOK_SPD_LO] <= rx_speed;
            end
        end
    end

endmodule

/* verilog/rrp_pkg.sv */
package rrp_pkg;

    // ------------------------------------------------------------------
    // Packet quadlet layout
    // ------------------------------------------------------------------
    localparam int         QUAD_W       = 32;
    localparam int         PID_HI       = 31;
    localparam int         PID_LO       = 30;
    localparam int         DEST_HI      = 29;
    localparam int         DEST_LO      = 24;
    localparam int         ZERO_HI      = 23;
    localparam int         ZERO_LO      = 22;
    localparam int         KIND_HI      = 21;
    localparam int         KIND_LO      = 18;
    localparam int         BANK_HI      = 17;
    localparam int         BANK_LO      = 15;
    localparam int         SOCK_HI      = 14;
    localparam int         SOCK_LO      = 11;
    localparam int         IDX_HI       = 10;
    localparam int         IDX_LO       = 8;
    localparam int         EXT_HI       = 7;
    localparam int         EXT_LO       = 4;
    localparam int         RSV_HI       = 3;
    localparam int         RSV_LO       = 0;

    localparam logic [1:0] PID_PHY      = 2'h0;
    localparam logic [3:0] EXT_PATTERN  = 4'he;
    localparam logic [3:0] KIND_BASE    = 4'h1;
    localparam logic [3:0] KIND_PAGED   = 4'h5;
    localparam logic [3:0] PAGED_BASE   = 4'h8;

    // ------------------------------------------------------------------
    // Packet control token layout
    // ------------------------------------------------------------------
    localparam int         TOK_LEN_HI   = 29;
    localparam int         TOK_LEN_LO   = 16;
    localparam int         TOK_LEN_W    = 14;
    localparam logic [TOK_LEN_W-1:0] REPLY_LEN = 14'h2;
    localparam int         TOK_SELF     = 15;
    localparam int         TOK_PHY      = 14;
    localparam int         TOK_ACK_HI   = 12;
    localparam int         TOK_ACK_LO   = 8;
    localparam int         TOK_PAD_HI   = 7;
    localparam int         TOK_PAD_LO   = 6;
    localparam int         TOK_SPD_HI   = 5;
    localparam int         TOK_SPD_LO   = 4;
    localparam logic [1:0] PAD_NONE     = 2'h0;

    localparam logic [1:0] RATE_100     = 2'h0;
    localparam logic [1:0] RATE_200     = 2'h1;
    localparam logic [1:0] RATE_400     = 2'h2;
    localparam logic [1:0] RATE_BAD     = 2'h3;

    typedef enum logic [1:0] {
        RRP_TX_IDLE,
        RRP_TX_FIRST,
        RRP_TX_SECOND
    } rrp_tx_state_t;

endpackage

/* verif/rrp_framer_assertions.sv */
`timescale 1ns/1ns
module rrp_framer_assertions (
    // Clock and reset
    input wire logic                            mclk,
    input wire logic                            rst_b,
    // Host request
    input wire logic                            req_valid,
    input wire logic                            req_ready,
    input wire logic                            req_paged,
    input wire logic [5:0]                      req_dest_node,
    input wire logic [2:0]                      req_bank,
    input wire logic [3:0]                      req_socket,
    input wire logic [2:0]                      req_index,
    input wire logic [3:0]                      req_target_register,
    input wire logic                            req_outstanding,
    // Local PHY side
    input wire logic                            tx_valid,
    input wire logic                            tx_ready,
    input wire logic [rrp_pkg::QUAD_W-1:0]      tx_data,
    input wire logic                            tx_last,
    input wire logic                            rx_valid,
    input wire logic                            rx_last,
    input wire logic                            rx_selfid,
    input wire logic [4:0]                      rx_ack,
    input wire logic [1:0]                      rx_speed,
    // Reply and token
    input wire logic                            rpl_valid,
    input wire logic                            rpl_paged,
    input wire logic [2:0]                      rpl_index,
    input wire logic [3:0]                      rpl_target_register,
    input wire logic                            token_valid,
    input wire logic [rrp_pkg::TOK_LEN_W-1:0]   token_length_quadlets,
    input wire logic                            token_selfid,
    input wire logic                            token_phy_packet,
    input wire logic [4:0]                      acknowledge_value,
    input wire logic [1:0]                      token_pad,
    input wire logic [1:0]                      token_rate
);
    import rrp_pkg::*;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // ------------
    // Transmit
    // ------------
    a_first_fixed: assert property (
        tx_valid && !tx_last |-> tx_data[31:30] == 2'h0 && tx_data[23:22] == 2'h0 && tx_data[7:0] == 8'he0)
        else $error("first quadlet fixed bits wrong");
    a_second_compl: assert property (
        tx_valid && tx_ready && !tx_last |=> tx_valid && tx_last && tx_data == ~$past(tx_data))
        else $error("second quadlet is not the complement");
    a_take_fields: assert property (
        req_valid && req_ready |=> tx_valid && !tx_last && tx_data[29:24] == $past(req_dest_node)
        && tx_data[21:8] == {($past(req_paged) ? 4'h5 : 4'h1), $past(req_bank), $past(req_socket), $past(req_index)})
        else $error("request fields misplaced");
    a_target_reg: assert property (
        req_valid && req_ready |=> req_target_register == {$past(req_paged), $past(req_index)})
        else $error("target register wrong");
    a_ready_low: assert property (req_valid && req_ready |=> !req_ready [*2])
        else $error("request taken while busy");
    a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("quadlet changed before taken");
    a_sent_flags: assert property (tx_valid && tx_ready && tx_last |=> req_outstanding && req_ready && !tx_valid)
        else $error("outstanding not set after send");

    // ------------
    // Receive
    // ------------
    a_token_fields: assert property (
        rx_valid && rx_last |=> token_valid && token_selfid == $past(rx_selfid) && token_pad == 2'h0
        && acknowledge_value == $past(rx_ack) && token_rate == $past(rx_speed))
        else $error("token fields wrong");
    a_reply_token: assert property (
        rpl_valid |-> token_valid && token_length_quadlets == 14'h2 && token_phy_packet && !token_selfid)
        else $error("reply token wrong");
    a_reply_target: assert property (rpl_valid |-> rpl_target_register == {rpl_paged, rpl_index})
        else $error("reply target register wrong");

    c_paged_reply: cover property (rpl_valid && rpl_paged);
    c_base_reply: cover property (rpl_valid && !rpl_paged);
    c_tx_stall: cover property (tx_valid && !tx_ready);
endmodule

/* verif/rrp_phy_model.sv */
`timescale 1ns/1ns
module rrp_phy_model (
    // Clock and reset
    input  wire logic                           mclk,
    input  wire logic                           rst_b,
    // Transmit quadlets from the block
    input  wire logic                           tx_valid,
    output logic                                tx_ready,
    input  wire logic [rrp_pkg::QUAD_W-1:0]     tx_data,
    input  wire logic                           tx_last,
    // Receive quadlets toward the block
    output logic                                rx_valid,
    output logic [rrp_pkg::QUAD_W-1:0]          rx_data,
    output logic                                rx_last,
    output logic                                rx_selfid,
    output logic [4:0]                          rx_ack,
    output logic [1:0]                          rx_speed
);
    import rrp_pkg::*;
    logic [31:0] cap0 = 32'h0;
    logic [31:0] cap1 = 32'h0;
    logic        slow = 1'h0;
    logic        pend = 1'h0;
    logic [4:0]  ack_val = 5'h0;
    logic [1:0]  spd_val = 2'h0;

    initial begin
        tx_ready = 1'h0;
        rx_valid = 1'h0;
        rx_data = 32'h0;
        rx_last = 1'h0;
        rx_selfid = 1'h0;
        rx_ack = 5'h0;
        rx_speed = 2'h0;
    end

    // A slow far end is ready only on every other cycle.
    always @(negedge mclk) begin
        tx_ready <= !slow || !tx_ready;
    end

    always @(posedge mclk) begin
        if (rst_b && tx_valid && tx_ready) begin
            if (tx_last) begin
                cap1 <= tx_data;
                pend <= 1'h1;
            end else begin
                cap0 <= tx_data;
            end
        end
    end

    task automatic send_pkt(input logic [31:0] q0, input logic [31:0] q1, input logic sid);
        @(negedge mclk);
        rx_valid = 1'h1;
        rx_data = q0;
        @(negedge mclk);
        rx_data = q1;
        rx_last = 1'h1;
        rx_selfid = sid;
        rx_ack = ack_val;
        rx_speed = spd_val;
        // Released lines must not keep their last value, or stale data could pass for good.
        @(negedge mclk);
        rx_valid = 1'h0;
        rx_last = 1'h0;
        rx_data = ~rx_data;
        rx_selfid = ~sid;
        rx_ack = ~rx_ack;
        rx_speed = ~rx_speed;
    endtask

    // The remote node answers with the same register fields and a complemented copy.
    always begin
        @(posedge mclk);
        if (pend) begin
            pend = 1'h0;
            send_pkt(cap0, ~cap0, 1'h0);
        end
    end
endmodule

/* verif/rrp_framer_tb_top.sv */
`timescale 1ns/1ns
module rrp_framer_tb_top;
    import rrp_pkg::*;
    logic                 mclk, rst_b, req_valid, req_ready, req_paged, saw_rpl;
    logic [5:0]           req_dest_node, rpl_dest_node;
    logic [2:0]           req_bank, req_index, rpl_bank, rpl_index;
    logic [3:0]           req_socket, req_target_register, rpl_socket, rpl_target_register;
    logic                 tx_valid, tx_ready, tx_last, rx_valid, rx_last, rx_selfid, token_valid;
    logic [31:0]          tx_data, rx_data, token_quadlet;
    logic [4:0]           rx_ack, acknowledge_value;
    logic [1:0]           rx_speed, token_pad, token_rate;
    logic                 rpl_valid, rpl_check_ok, rpl_expected, rpl_paged, req_outstanding;
    logic                 token_selfid, token_phy_packet, token_rate_unsupported;
    logic [TOK_LEN_W-1:0] token_length_quadlets;
    int                   n_errors = 0;
    int                   n_checks = 0;

    rrp_framer    DUT (.*);
    rrp_phy_model u_phy (.*);

    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_tok();
        saw_rpl = 1'h0;
        for (int k = 0; k < 40; k++) begin
            @(negedge mclk);
            if (token_valid === 1'h1) begin
                saw_rpl = rpl_valid;
                return;
            end
        end
        chk("token_valid", 32'h1, 32'h0);
    endtask

    task automatic tok_chk(input logic sid, input logic [4:0] ak, input logic [1:0] sp);
        chk("token_fields", {14'h2, sid, !sid, ak, 2'h0, sp},
            {token_length_quadlets, token_selfid, token_phy_packet, acknowledge_value, token_pad, token_rate});
        chk("token_quadlet", {2'h0, 14'h2, sid, !sid, 1'h0, ak, 2'h0, sp, 4'h0}, token_quadlet);
        chk("token_rate_unsupported", sp == 2'h3, token_rate_unsupported);
    endtask

    task automatic req_round(input logic p, input logic [5:0] d, input logic [2:0] b, input logic [3:0] s,
                             input logic [2:0] i, input logic sl, input logic [4:0] ak, input logic [1:0] sp);
        logic [31:0] q;
        q = {2'h0, d, 2'h0, (p ? 4'h5 : 4'h1), b, s, i, 4'he, 4'h0};
        u_phy.slow = sl;
        u_phy.ack_val = ak;
        u_phy.spd_val = sp;
        for (int k = 0; k < 20 && req_ready !== 1'h1; k++) @(negedge mclk);
        {req_valid, req_paged, req_dest_node, req_bank, req_socket, req_index} = {1'h1, p, d, b, s, i};
        @(negedge mclk);
        req_valid = 1'h0;
        chk("req_target_register", {p, i}, req_target_register);
        wait_tok();
        chk("tx_first", q, u_phy.cap0);
        chk("tx_second", ~q, u_phy.cap1);
        chk("rpl_valid", 32'h1, saw_rpl);
        chk("rpl_fields", {d, p, b, s, i}, {rpl_dest_node, rpl_paged, rpl_bank, rpl_socket, rpl_index});
        chk("rpl_target_register", {p, i}, rpl_target_register);
        chk("rpl_flags", 3'h6, {rpl_check_ok, rpl_expected, req_outstanding});
        tok_chk(1'h0, ak, sp);
    endtask

    task automatic inject(input logic [31:0] q0, input logic [31:0] q1, input logic sid,
                          input logic [4:0] ak, input logic [1:0] sp);
        u_phy.ack_val = ak;
        u_phy.spd_val = sp;
        fork
            u_phy.send_pkt(q0, q1, sid);
            wait_tok();
        join
    endtask

    task automatic t_base();
        req_round(1'h0, 6'h3f, 3'h5, 4'ha, 3'h7, 1'h0, 5'h11, 2'h0);
        req_round(1'h0, 6'h01, 3'h0, 4'h0, 3'h0, 1'h0, 5'h02, 2'h2);
        $display("t_base done");
    endtask

    task automatic t_paged_slow();
        req_round(1'h1, 6'h2a, 3'h7, 4'hf, 3'h7, 1'h1, 5'h1f, 2'h1);
        req_round(1'h1, 6'h00, 3'h2, 4'h5, 3'h0, 1'h1, 5'h0e, 2'h0);
        $display("t_paged_slow done");
    endtask

    task automatic t_rates();
        for (int k = 0; k < 4; k++) begin
            inject(32'h0504_2a00, ~32'h0504_2a00, 1'h0, 5'h04, k[1:0]);
            tok_chk(1'h0, 5'h04, k[1:0]);
            chk("rpl_expected", 32'h0, rpl_expected);
        end
        $display("t_rates done");
    endtask

    task automatic t_selfid();
        inject(32'h80ab_cd00, ~32'h80ab_cd00, 1'h1, 5'h00, 2'h2);
        chk("rpl_valid", 32'h0, saw_rpl);
        tok_chk(1'h1, 5'h00, 2'h2);
        $display("t_selfid done");
    endtask

    task automatic t_bad_compl();
        inject(32'h0216_4b00, ~32'h0216_4b00 ^ 32'h1, 1'h0, 5'h01, 2'h1);
        chk("rpl_check", 2'h2, {saw_rpl, rpl_check_ok});
        // A PHY packet of another extended kind yields a token but no reply.
        inject(32'h0520_0000, ~32'h0520_0000, 1'h0, 5'h01, 2'h1);
        chk("rpl_valid", 32'h0, saw_rpl);
        tok_chk(1'h0, 5'h01, 2'h1);
        $display("t_bad_compl done");
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_b = 1'h0;
        {req_valid, req_paged, req_dest_node, req_bank, req_socket, req_index} = 17'h0;
        repeat (16) @(negedge mclk);
        chk("reset_outputs", 32'h0, {tx_valid, rpl_valid, token_valid, req_outstanding, req_ready});
        rst_b = 1'h1;
        t_base();
        t_paged_slow();
        t_rates();
        t_selfid();
        t_bad_compl();
        conclude();
    end

    // A healthy run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        $display("[ERR] run_time expected finished seen timeout");
        conclude();
    end
endmodule

bind rrp_framer rrp_framer_assertions u_chk (.*);
